// ===== src/spm_pkg.sv
// Package for the signal peak monitor: register map, field layout, frame constants
package spm_pkg;
  // Register byte offsets on APB (printed offsets, all multiples of four)
  localparam logic [11:0] SPM_OFS_CTRL = 12'h270; // Monitor control
  localparam logic [11:0] SPM_OFS_PERIOD = 12'h274; // Period register
  localparam logic [11:0] SPM_OFS_EMB0 = 12'h278; // Embed enable A (0x0279 byte)
  localparam logic [11:0] SPM_OFS_EMB1 = 12'h27C; // Embed enable B (0x027A byte)
  localparam logic [11:0] SPM_OFS_HOLD = 12'h280; // Peak holding register
  localparam logic [11:0] SPM_OFS_STAT = 12'h284; // Status
  localparam logic [11:0] SPM_OFS_PATH = 12'h288; // Output path select
  // Field positions
  localparam int SPM_CTRL_EN_BIT = 1; // Peak detect enable
  localparam int SPM_EMB1_EN_BIT = 1; // Embed enable bit in second reg
  localparam logic [1:0] SPM_EMB0_EN_VAL = 2'h3; // Bits 1:0 must both be set
  localparam logic [2:0] SPM_PATH_RST = 3'h0; // Path select reset value
  localparam logic [2:0] SPM_PATH_SERIAL = 3'h7; // All three path bits set
  localparam int SPM_PEAK_W = 13; // Peak value width
  localparam int SPM_PERIOD_W = 24; // Period width
  localparam logic [23:0] SPM_PERIOD_RST = 24'h00_0050; // Period reset value
  localparam logic [23:0] SPM_TIMER_END = 24'h00_0001; // Transfer at count 1
  // Frame layout
  localparam int SPM_FRAME_W = 25; // Bits per frame
  localparam int SPM_SUB_W = 5; // Bits per subframe
  localparam logic [3:0] SPM_FRAME_ID = 4'h1; // Identifier bits 0001
  localparam logic [4:0] SPM_IDLE_SUB = 5'h1F; // Idle subframe of ones
  localparam logic [4:0] SPM_BIT_CNT_LAST = 5'h18; // Index of last frame bit
  localparam logic [31:0] SPM_RD_ZERO = 32'h0000_0000; // Unmapped read value

  // Sample in: signed value with valid
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } spm_sample_t;

  // APB request group
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } spm_apb_req_t;
endpackage

// ===== src/spm_fifo.sv
// Parameterised valid/ready FIFO for peak words headed to the serialiser
module spm_fifo
  import spm_pkg::*;
#(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  // Depth must be a power of two at least 2
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("spm_fifo: bad DEPTH or WIDTH");
  end

  // Pointer and count state in one struct; storage array kept apart
  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } spm_fifo_state_t;

  spm_fifo_state_t st_reg;
  spm_fifo_state_t st_next;
  logic [WIDTH-1:0] mem [DEPTH]; // Storage array
  logic push;
  logic pop;

  // Handshake flags
  assign o_in_ready = (st_reg.count != (AW+1)'(DEPTH));
  assign o_out_valid = (st_reg.count != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[st_reg.rd_ptr];

  // Pointer and count update
  always_comb
  begin
    st_next = st_reg;
    if (push)
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
    if (pop)
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    if (push && !pop)
      st_next.count = st_reg.count + 1'b1;
    else if (pop && !push)
      st_next.count = st_reg.count - 1'b1;
  end

  // State register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // Storage write, no reset needed
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[st_reg.wr_ptr] <= i_in_data;
  end
endmodule

// ===== src/spm_top.sv
// Signal peak monitor with APB registers and framed serial control-bit output
// What this block does
// (RL1) Capture largest sample magnitude, sign ignored
// (RL2) Peak is a 13-bit unsigned value
// (RL3) Hold a 24-bit observation period in samples
// (RL4) Peak detect enabled by control bit 1
// (RL5) Host writes period before enabling detection
// (RL6) Enable loads timer; decrements each sample
// (RL7) Keep greater of input and stored magnitude
// (RL8) Seed store with current sample, not zero
// (RL9) Timer at 1 copies peak to holding
// (RL10) Reload timer, reseed store, keep comparing
// (RL11) Embed only when both enable fields set
// (RL12) Up to three control bits, MSB first
// (RL13) With one control bit, use the MSB
// (RL14) Serial output needs path select configured
// (RL15) 25-bit frame, MSB first, five subframes
// (RL16) Each subframe starts with a zero bit
// (RL17) ID 0001, then peak bits, three zero pad
// (RL18) Idle subframes of ones between frames; a word already in the FIFO goes out after one idle bit of one
module spm_top
  import spm_pkg::*;
#(
  parameter int SAMPLE_W = 16, // Input sample width
  parameter int FIFO_DEPTH = 8 // Peak word buffer depth
)
(
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_SAMPLE_VALID,
  input wire logic [SAMPLE_W-1:0] I_SAMPLE,
  input wire logic [1:0] I_CS_COUNT,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_CTRL_VALID,
  output logic [2:0] O_CTRL_BITS
);
  // Samples of 14 to 32 bits are scaled down to the peak width; other widths refused
  initial
  begin
    if (SAMPLE_W < SPM_PEAK_W + 1 || SAMPLE_W > 32)
      $error("spm_top: SAMPLE_W out of range");
  end

  // Serialiser phase
  typedef enum logic [0:0] {SER_IDLE, SER_FRAME} spm_ser_t;

  // All state of the block except the peak word FIFO
  typedef struct packed {
    logic ctrl_en; // Peak detect enable
    logic [SPM_PERIOD_W-1:0] period; // Period register
    logic [1:0] emb0; // Embed enable field A
    logic emb1; // Embed enable field B
    logic [2:0] path; // Output path select
    logic running; // Measurement in progress
    logic [SPM_PERIOD_W-1:0] timer; // Countdown timer
    logic [SPM_PEAK_W-1:0] store; // Internal magnitude store
    logic [SPM_PEAK_W-1:0] hold; // Holding register
    logic hold_new; // Holding updated since last status read
    logic overflow; // Peak word dropped, FIFO full
    spm_ser_t ser; // Serialiser phase
    logic [4:0] bit_idx; // Bit index inside frame or idle subframe
    logic [SPM_FRAME_W-1:0] shreg; // Frame shift register
    logic [2:0] cbits; // Control bits out
    logic cvalid; // Control bits valid
    logic [31:0] prdata; // APB read data
  } spm_state_t;

  spm_state_t st_reg;
  spm_state_t st_next;
  logic wr_acc; // APB write access phase
  logic rd_acc; // APB read setup phase
  logic embed_on; // Serial output fully enabled
  logic [SPM_PEAK_W-1:0] mag; // Current sample magnitude
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [SPM_PEAK_W-1:0] fifo_out_data;
  logic xfer; // Timer transfer event
  logic push;

  // Magnitude of a signed sample, scaled to peak width
  function automatic logic [SPM_PEAK_W-1:0] magnitude(input logic [SAMPLE_W-1:0] s);
    logic [SAMPLE_W-1:0] a;
    a = s[SAMPLE_W-1] ? (~s + 1'b1) : s;
    // Most negative code saturates to full scale
    if (a[SAMPLE_W-1])
      magnitude = '1;
    else
      magnitude = a[SAMPLE_W-2 -: SPM_PEAK_W];
  endfunction

  // Build a 25-bit frame from a peak value
  function automatic logic [SPM_FRAME_W-1:0] make_frame(input logic [SPM_PEAK_W-1:0] p);
    make_frame = {1'b0, SPM_FRAME_ID, 1'b0, p[12:9], 1'b0, p[8:5],
                  1'b0, p[4:1], 1'b0, p[0], 3'b000}; // [RL16] [RL17]
  endfunction

  // APB decode, zero wait states
  assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd_acc = I_PSEL && !I_PENABLE && !I_PWRITE;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = 1'b0;
  assign O_PRDATA = st_reg.prdata;
  assign O_CTRL_VALID = st_reg.cvalid;
  assign O_CTRL_BITS = st_reg.cbits;

  // Serial output active only when all enables and path are set
  assign embed_on = (st_reg.emb0 == SPM_EMB0_EN_VAL) && st_reg.emb1 // [RL11]
                    && (st_reg.path == SPM_PATH_SERIAL); // [RL14]
  assign mag = magnitude(I_SAMPLE); // [RL1] [RL2]
  assign xfer = st_reg.running && I_SAMPLE_VALID && (st_reg.timer == SPM_TIMER_END);
  assign push = xfer && embed_on;
  assign fifo_pop = embed_on && I_SAMPLE_VALID && (st_reg.ser == SER_IDLE)
                    && (st_reg.bit_idx == 5'(SPM_SUB_W - 1)) && fifo_out_valid;

  // Peak words queue for the serialiser
  spm_fifo #(
    .WIDTH(SPM_PEAK_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_in_valid(push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(st_reg.store >= mag ? st_reg.store : mag),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out_data)
  );

  // Next-state logic
  always_comb
  begin
    logic [SPM_PEAK_W-1:0] greater;
    logic sbit;
    greater = (st_reg.store >= mag) ? st_reg.store : mag; // [RL7]
    sbit = 1'b1;
    st_next = st_reg;
    // Read data holds from setup edge until the next read setup

    // Register writes
    if (wr_acc)
    begin
      case (I_PADDR)
        SPM_OFS_CTRL: st_next.ctrl_en = I_PWDATA[SPM_CTRL_EN_BIT];
        SPM_OFS_PERIOD: st_next.period = I_PWDATA[SPM_PERIOD_W-1:0]; // [RL3]
        SPM_OFS_EMB0: st_next.emb0 = I_PWDATA[1:0];
        SPM_OFS_EMB1: st_next.emb1 = I_PWDATA[SPM_EMB1_EN_BIT];
        SPM_OFS_PATH: st_next.path = I_PWDATA[2:0];
        default: st_next.path = st_reg.path; // Unmapped write ignored
      endcase
    end

    // Register reads, data ready in access phase
    if (rd_acc)
    begin
      case (I_PADDR)
        SPM_OFS_CTRL: st_next.prdata = 32'(st_reg.ctrl_en) << SPM_CTRL_EN_BIT;
        SPM_OFS_PERIOD: st_next.prdata = 32'(st_reg.period);
        SPM_OFS_EMB0: st_next.prdata = 32'(st_reg.emb0);
        SPM_OFS_EMB1: st_next.prdata = 32'(st_reg.emb1) << SPM_EMB1_EN_BIT;
        SPM_OFS_HOLD: st_next.prdata = 32'(st_reg.hold); // [RL9]
        SPM_OFS_STAT: st_next.prdata = {28'h000_0000, st_reg.overflow,
                                        st_reg.hold_new, embed_on, st_reg.running};
        SPM_OFS_PATH: st_next.prdata = 32'(st_reg.path);
        default: st_next.prdata = SPM_RD_ZERO; // Unmapped reads zero
      endcase
      // Status read clears sticky flags
      if (I_PADDR == SPM_OFS_STAT)
      begin
        st_next.hold_new = 1'b0;
        st_next.overflow = 1'b0;
      end
    end

    // Peak detector; period must already be written when enabled
    if (!st_reg.ctrl_en) // [RL4] [RL5]
    begin
      st_next.running = 1'b0;
    end
    else if (I_SAMPLE_VALID)
    begin
      if (!st_reg.running)
      begin
        // Start: load timer, seed with this sample
        st_next.running = 1'b1;
        st_next.timer = st_reg.period; // [RL6]
        st_next.store = mag; // [RL8]
      end
      else if (xfer)
      begin
        // Transfer, then restart measurement
        st_next.hold = greater; // [RL9]
        st_next.hold_new = 1'b1; // Set wins over read-clear
        st_next.timer = st_reg.period; // [RL10]
        st_next.store = mag; // [RL10]
        if (push && !fifo_in_ready)
          st_next.overflow = 1'b1;
      end
      else
      begin
        st_next.timer = st_reg.timer - 1'b1; // [RL6]
        st_next.store = greater; // [RL7]
      end
    end

    // Serialiser, one bit per sample
    st_next.cvalid = I_SAMPLE_VALID;
    if (!embed_on)
    begin
      st_next.ser = SER_IDLE;
      st_next.bit_idx = '0;
      st_next.cbits = '0;
    end
    else if (I_SAMPLE_VALID)
    begin
      case (st_reg.ser)
        SER_IDLE:
        begin
          sbit = SPM_IDLE_SUB[SPM_SUB_W-1]; // [RL18]
          if (fifo_pop)
          begin
            st_next.ser = SER_FRAME;
            st_next.bit_idx = '0;
            st_next.shreg = make_frame(fifo_out_data);
          end
          else if (st_reg.bit_idx == 5'(SPM_SUB_W - 1))
            st_next.bit_idx = '0;
          else
            st_next.bit_idx = st_reg.bit_idx + 1'b1;
        end
        SER_FRAME:
        begin
          sbit = st_reg.shreg[SPM_FRAME_W-1]; // [RL15]
          st_next.shreg = {st_reg.shreg[SPM_FRAME_W-2:0], 1'b1};
          if (st_reg.bit_idx == SPM_BIT_CNT_LAST)
          begin
            st_next.ser = SER_IDLE;
            st_next.bit_idx = 5'(SPM_SUB_W - 1);
          end
          else
            st_next.bit_idx = st_reg.bit_idx + 1'b1;
        end
        default: st_next.ser = SER_IDLE;
      endcase
      // Monitor bit in MSB control slot; others zero
      case (I_CS_COUNT) // [RL12]
        2'd0: st_next.cbits = 3'b000;
        default: st_next.cbits = {sbit, 2'b00}; // [RL13]
      endcase
    end
  end

  // State register
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      st_reg <= '0;
      st_reg.period <= SPM_PERIOD_RST;
      st_reg.path <= SPM_PATH_RST;
      st_reg.ser <= SER_IDLE;
    end
    else
      st_reg <= st_next;
  end
endmodule

// ===== dv/spm_top_asserts.sv
// Port checker for the peak monitor: register reads and serial frame shape
module spm_top_asserts
  import spm_pkg::*;
#(
  parameter int SAMPLE_W = 16,
  parameter int FIFO_DEPTH = 8
)
(
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_SAMPLE_VALID,
  input wire logic [SAMPLE_W-1:0] I_SAMPLE,
  input wire logic [1:0] I_CS_COUNT,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic O_CTRL_VALID,
  input wire logic [2:0] O_CTRL_BITS
);
  logic inf_reg; // Inside a frame
  logic last_reg; // Previous serial bit
  logic [4:0] pos_reg; // Bit index in frame
  // Tracks frame position: a one then a zero opens a frame
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      inf_reg <= 1'b0;
      last_reg <= 1'b0;
      pos_reg <= 5'h01;
    end
    else if (O_CTRL_VALID)
    begin
      last_reg <= O_CTRL_BITS[2];
      if (!inf_reg)
        inf_reg <= last_reg && !O_CTRL_BITS[2];
      else
      begin
        pos_reg <= (pos_reg == 5'h18) ? 5'h01 : pos_reg + 5'h01;
        inf_reg <= pos_reg != 5'h18;
      end
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_rd;
    I_PSEL && !I_PENABLE && !I_PWRITE;
  endsequence
  sequence s_fr;
    O_CTRL_VALID && inf_reg;
  endsequence
  property p_cv;
    !I_SYS_RST |=> O_CTRL_VALID == $past(I_SAMPLE_VALID);
  endproperty
  property p_low;
    O_CTRL_BITS[1:0] == 2'h0;
  endproperty
  property p_cs0;
    I_SAMPLE_VALID && I_CS_COUNT == 2'h0 |=> O_CTRL_BITS == 3'h0;
  endproperty
  property p_hold;
    s_rd ##0 (I_PADDR == SPM_OFS_HOLD) |=> O_PRDATA[31:13] == 19'h0_0000;
  endproperty
  property p_per;
    s_rd ##0 (I_PADDR == SPM_OFS_PERIOD) |=> O_PRDATA[31:24] == 8'h00;
  endproperty
  property p_ctl;
    s_rd ##0 (I_PADDR == SPM_OFS_CTRL) |=> {O_PRDATA[31:2], O_PRDATA[0]} == 31'h0000_0000;
  endproperty
  property p_sub;
    s_fr ##0 (pos_reg inside {5'h05, 5'h0A, 5'h0F, 5'h14}) |-> !O_CTRL_BITS[2];
  endproperty
  property p_id;
    s_fr ##0 (pos_reg <= 5'h04) |-> O_CTRL_BITS[2] == (pos_reg == 5'h04);
  endproperty
  property p_pad;
    s_fr ##0 (pos_reg >= 5'h16) |-> !O_CTRL_BITS[2];
  endproperty
  a_cv: assert property (p_cv) else $error("Control valid not one cycle after sample");
  a_low: assert property (p_low) else $error("Unused control bits set");
  a_cs0: assert property (p_cs0) else $error("Control bit with none configured");
  a_hold: assert property (p_hold) else $error("Holding read wider than peak");
  a_per: assert property (p_per) else $error("Period read wider than field");
  a_ctl: assert property (p_ctl) else $error("Control read has stray bits");
  a_sub: assert property (p_sub) else $error("Subframe start bit not zero");
  a_id: assert property (p_id) else $error("Identifier bits wrong");
  a_pad: assert property (p_pad) else $error("Frame tail not zero");
endmodule
bind spm_top spm_top_asserts #(.SAMPLE_W(SAMPLE_W), .FIFO_DEPTH(FIFO_DEPTH)) u_asserts (
  .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_SAMPLE_VALID(I_SAMPLE_VALID),
  .I_SAMPLE(I_SAMPLE), .I_CS_COUNT(I_CS_COUNT), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_CTRL_VALID(O_CTRL_VALID),
  .O_CTRL_BITS(O_CTRL_BITS)
);

// ===== dv/spm_rx_model.sv
// Receiver model: deserialises monitor frames from the top control bit
module spm_rx_model
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_on,
  input wire logic i_valid,
  input wire logic [2:0] i_bits,
  output logic [12:0] o_peak,
  output logic [7:0] o_frames,
  output logic o_bad
);
  logic [24:0] sh; // Frame shift register
  logic [4:0] cnt; // Bits taken, zero while hunting
  // Hunt for a zero start bit, then collect 25 bits
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt <= 5'h00;
      o_frames <= 8'h00;
      o_bad <= 1'b0;
    end
    else if (i_on && i_valid && (cnt != 5'h00 || !i_bits[2]))
    begin
      sh <= {sh[23:0], i_bits[2]};
      cnt <= (cnt == 5'h18) ? 5'h00 : cnt + 5'h01;
      if (cnt == 5'h18)
        fin({sh[23:0], i_bits[2]});
    end
  end
  // Validates start bits and identifier, keeps the peak
  task automatic fin(input logic [24:0] f);
    o_frames <= o_frames + 8'h01;
    o_peak <= {f[18:15], f[13:10], f[8:5], f[3]};
    if ({f[24], f[19], f[14], f[9], f[4]} != 5'h00 || f[23:20] != 4'h1 || f[2:0] != 3'h0)
      o_bad <= 1'b1;
  endtask
endmodule

// ===== dv/spm_top_test.sv
// Self-checking bench for the signal peak monitor
module spm_top_test
  import spm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sv = 1'b0;
  logic [15:0] sd = 16'h0000;
  logic [1:0] cs = 2'h0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pw = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pd = 32'h0000_0000;
  logic [31:0] prdata, r;
  logic pready, cvld, rx_bad, en, st;
  logic rx_on = 1'b0;
  logic [2:0] cbits;
  logic [12:0] rx_peak, sto;
  logic [12:0] hold = 13'h0000;
  logic [7:0] rx_frames, f0;
  logic [23:0] per, tm;
  logic [11:0] ra[8] = '{SPM_OFS_CTRL, SPM_OFS_PERIOD, SPM_OFS_EMB0, SPM_OFS_EMB1,
    SPM_OFS_HOLD, SPM_OFS_STAT, SPM_OFS_PATH, 12'h2FC};
  int err_count = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  spm_top #(.SAMPLE_W(16), .FIFO_DEPTH(8)) dut (.I_CLK(clk), .I_SYS_RST(rst),
    .I_SAMPLE_VALID(sv), .I_SAMPLE(sd), .I_CS_COUNT(cs), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pw), .I_PADDR(pa), .I_PWDATA(pd), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(), .O_CTRL_VALID(cvld), .O_CTRL_BITS(cbits));
  spm_rx_model u_rx (.i_clk(clk), .i_rst(rst), .i_on(rx_on), .i_valid(cvld),
    .i_bits(cbits), .o_peak(rx_peak), .o_frames(rx_frames), .o_bad(rx_bad));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One APB transfer; read data lands in r
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pw <= w;
    pa <= a;
    pd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 50)
    begin
      err_count++;
      summarize();
    end
    // Read data taken at the edge that samples ready, then release
    r = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Magnitude as the peak detector sees it, sign dropped
  function automatic logic [12:0] mag(input logic [15:0] s);
    logic [15:0] a;
    a = s[15] ? -s : s;
    return (s == 16'h8000) ? 13'h1FFF : a[14:2];
  endfunction
  // Drives one sample and steps the reference peak model
  task automatic smp(input logic v, input logic [1:0] c);
    logic [15:0] d;
    logic [12:0] m;
    d = ($urandom_range(0, 5) == 0) ? 16'h8000 : 16'($urandom);
    @(posedge clk);
    sv <= v;
    sd <= d;
    cs <= c;
    m = mag(d);
    if (v && en)
    begin
      if (st && tm == 24'h00_0001)
        hold = (m > sto) ? m : sto;
      if (!st || tm == 24'h00_0001)
      begin
        tm = per;
        sto = m;
        st = 1'b1;
      end
      else
      begin
        tm = tm - 24'h00_0001;
        sto = (m > sto) ? m : sto;
      end
    end
  endtask
  // Period written before enable, then period read back
  task automatic ctl(input logic [23:0] p, input logic e);
    apb(1'b1, SPM_OFS_CTRL, 32'h0000_0000);
    apb(1'b1, SPM_OFS_PERIOD, {8'hA5, p});
    apb(1'b1, SPM_OFS_CTRL, {30'h0000_0000, e, 1'b0});
    per = p;
    en = e;
    st = 1'b0;
    apb(1'b0, SPM_OFS_PERIOD, 32'h0000_0000);
    chk(r, {8'h00, p});
  endtask
  initial
  begin
    void'($urandom(17));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i])
    begin
      apb(1'b0, ra[i], 32'h0000_0000);
      chk(r, (i == 1) ? 32'h0000_0050 : 32'h0000_0000);
    end
    $display("Reset values done");
    repeat (6)
    begin
      ctl(24'($urandom_range(1, 6)), $urandom_range(0, 3) != 0);
      repeat ($urandom_range(8, 30)) smp($urandom_range(0, 3) != 0, 2'($urandom));
      smp(1'b0, 2'h0);
      apb(1'b0, SPM_OFS_HOLD, 32'h0000_0000);
      chk(r, {19'h0_0000, hold});
    end
    $display("Peak rounds done");
    apb(1'b1, SPM_OFS_EMB0, 32'h0000_0003);
    apb(1'b1, SPM_OFS_EMB1, 32'h0000_0002);
    apb(1'b1, SPM_OFS_PATH, 32'h0000_0007);
    rx_on <= 1'b1;
    f0 = rx_frames;
    ctl(24'h00_0028, 1'b1);
    repeat (200) smp(1'b1, 2'($urandom_range(1, 3)));
    smp(1'b0, 2'h1);
    chk(rx_frames - f0, 32'h0000_0004);
    chk(rx_peak, hold);
    $display("Serial frames done");
    ctl(24'h00_0001, 1'b1);
    repeat (24) smp(1'b1, 2'($urandom_range(1, 3)));
    smp(1'b0, 2'h1);
    apb(1'b0, SPM_OFS_STAT, 32'h0000_0000);
    chk(r[3], 1'b1);
    apb(1'b0, SPM_OFS_STAT, 32'h0000_0000);
    chk(r[3], 1'b0);
    ctl(24'h00_0001, 1'b0);
    f0 = rx_frames;
    repeat (420) smp($urandom_range(0, 3) != 0, 2'($urandom_range(1, 3)));
    chk(rx_frames - f0 >= 8'h08, 1'b1);
    chk(rx_bad, 1'b0);
    $display("Fill and drain done");
    summarize();
  end
endmodule
